// File: verilog/dfp_top.sv
// dual fast pwm: register file, shared counter and two channels
//
// Local design decision: the AXI4-Lite slave port.
`timescale 1ns/100ps
`default_nettype none
`include "dfp_cfg.svh"
module dfp_top #(
  parameter int AW = 8,
  parameter int DW = 8,
  parameter int NCH = 2
) (
  // clock, reset, enable
  input  wire logic            aclk,
  input  wire logic            aresetn,
  input  wire logic            ce,
  // axi4-lite write address
  input  wire logic            s_axi_awvalid,
  output logic                 s_axi_awready,
  input  wire logic [AW-1:0]   s_axi_awaddr,
  input  wire logic [2:0]      s_axi_awprot,
  // axi4-lite write data
  input  wire logic            s_axi_wvalid,
  output logic                 s_axi_wready,
  input  wire logic [31:0]     s_axi_wdata,
  input  wire logic [3:0]      s_axi_wstrb,
  // axi4-lite write response
  output logic                 s_axi_bvalid,
  input  wire logic            s_axi_bready,
  output logic [1:0]           s_axi_bresp,
  // axi4-lite read address
  input  wire logic            s_axi_arvalid,
  output logic                 s_axi_arready,
  input  wire logic [AW-1:0]   s_axi_araddr,
  input  wire logic [2:0]      s_axi_arprot,
  // axi4-lite read data
  output logic                 s_axi_rvalid,
  input  wire logic            s_axi_rready,
  output logic [31:0]          s_axi_rdata,
  output logic [1:0]           s_axi_rresp,
  // pwm pins, active low pulses
  output logic                 pwm_out_ch0,
  output logic                 pwm_out_ch1
);
  import dfp_pkg::*;

  // the register layout holds exactly eight duty bits and two channels
  if (DW != 8) begin : g_dw_chk
    $error("dfp_top: DW must be 8");
  end
  if (NCH != 2) begin : g_nch_chk
    $error("dfp_top: NCH must be 2");
  end

  // write strobe from the bus front end
  dfp_wr_s         wr;
  logic [AW-3:0]   rd_idx;
  logic [31:0]     rd_data;
  logic            rd_hit;
  logic            wr_hit;

  // control, duty and timing state
  dfp_ctrl_s       ctrl_reg;
  dfp_ctrl_s       ctrl_next;
  logic [DW-1:0]   duty_reg [NCH];
  logic [DW-1:0]   act_reg  [NCH];
  logic [7:0]      cnt_reg;
  logic [7:0]      cnt_next;
  logic [1:0]      phase_reg;
  logic [1:0]      phase_next;
  logic [7:0]      cnt_last;
  logic [NCH-1:0]  pin;
  logic [NCH-1:0]  en_vec;

  // protection bits and upper strobes carry no meaning here
  wire             unused_ok = &{1'b0, s_axi_awprot, s_axi_arprot,
                                 s_axi_wstrb[3:1], s_axi_wdata[31:8]};

  // bus front end
  dfp_axil_slave #(
    .AW      (AW)
  ) u_bus (
    .aclk    (aclk),
    .aresetn (aresetn),
    .ce      (ce),
    .awvalid (s_axi_awvalid),
    .awready (s_axi_awready),
    .awaddr  (s_axi_awaddr),
    .wvalid  (s_axi_wvalid),
    .wready  (s_axi_wready),
    .wdata   (s_axi_wdata[7:0]),
    .wstrb0  (s_axi_wstrb[0]),
    .bvalid  (s_axi_bvalid),
    .bready  (s_axi_bready),
    .bresp   (s_axi_bresp),
    .arvalid (s_axi_arvalid),
    .arready (s_axi_arready),
    .araddr  (s_axi_araddr),
    .rvalid  (s_axi_rvalid),
    .rready  (s_axi_rready),
    .rdata   (s_axi_rdata),
    .rresp   (s_axi_rresp),
    .wr      (wr),
    .wr_hit  (wr_hit),
    .rd_idx  (rd_idx),
    .rd_data (rd_data),
    .rd_hit  (rd_hit)
  );

  // write address decode; the index from address bits 7:2 must match, higher address bits are not decoded
  wire             wr_top_zero = (wr.idx[5:4] == 2'b00);
  wire             wr_ctrl     = wr.wr & (wr.idx == `DFP_IDX_CTRL);
  wire             wr_duty0    = wr.wr & (wr.idx == `DFP_IDX_DUTY0);
  wire             wr_duty1    = wr.wr & (wr.idx == `DFP_IDX_DUTY1);
  wire             hit_ctrl_w  = (wr.idx == `DFP_IDX_CTRL);
  wire             hit_duty0_w = (wr.idx == `DFP_IDX_DUTY0);
  wire             hit_duty1_w = (wr.idx == `DFP_IDX_DUTY1);
  wire             hit_stat_w  = (wr.idx == `DFP_IDX_STAT);
  assign wr_hit = wr_top_zero & (hit_ctrl_w | hit_duty0_w | hit_duty1_w | hit_stat_w);

  // read address decode, upper index bits must be clear
  wire             rd_top_zero = (rd_idx[AW-3:4] == '0);
  wire [3:0]       rd_low      = rd_idx[3:0];
  wire             rd_ctrl     = rd_top_zero & (rd_low == `DFP_IDX_CTRL);
  wire             rd_duty0    = rd_top_zero & (rd_low == `DFP_IDX_DUTY0);
  wire             rd_duty1    = rd_top_zero & (rd_low == `DFP_IDX_DUTY1);
  wire             rd_stat     = rd_top_zero & (rd_low == `DFP_IDX_STAT);
  assign rd_hit = rd_ctrl | rd_duty0 | rd_duty1 | rd_stat;

  // read data select; unused upper bits read as zero
  wire [31:0]      rd_ctrl_w   = {24'h00_0000, ctrl_reg};
  wire [31:0]      rd_duty0_w  = {24'h00_0000, duty_reg[0]};
  wire [31:0]      rd_duty1_w  = {24'h00_0000, duty_reg[1]};
  wire [31:0]      rd_stat_w   = {22'h00_0000, phase_reg, cnt_reg};
  assign rd_data = rd_ctrl  ? rd_ctrl_w  :
                   rd_duty0 ? rd_duty0_w :
                   rd_duty1 ? rd_duty1_w :
                   rd_stat  ? rd_stat_w  : 32'h0000_0000;

  // written control value with reserved bits forced to zero
  wire dfp_ctrl_s  ctrl_in   = dfp_ctrl_s'(wr.data & `DFP_CTRL_MASK);
  // a write that takes a running counter to stop
  wire             run_fall  = wr_ctrl & ctrl_reg.run & ~ctrl_in.run;

  // control next value: stopping clears mode and enables
  always_comb begin
    if (run_fall) begin
      ctrl_next = dfp_ctrl_s'(`DFP_CTRL_RST);
    end else if (wr_ctrl) begin
      ctrl_next = ctrl_in;
    end else begin
      ctrl_next = ctrl_reg;
    end
  end

  // control register
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      ctrl_reg <= dfp_ctrl_s'(`DFP_CTRL_RST);
    end else if (ce) begin
      ctrl_reg <= ctrl_next;
    end
  end

  // last count of a period; one setting for both channels
  always_comb begin
    case (ctrl_reg.mode)
      DFP_M7:  cnt_last = `DFP_LAST_M7;
      DFP_M6:  cnt_last = `DFP_LAST_M6;
      default: cnt_last = `DFP_LAST_M8;
    endcase
  end

  // end of the current period
  wire             wrap      = (cnt_reg == cnt_last);
  // the moment a new duty value may be taken over
  wire             take_duty = ~ctrl_reg.run | wrap;

  // shared up counter and dither phase
  always_comb begin
    if (!ctrl_reg.run) begin
      cnt_next = 8'h00;
      phase_next = 2'b00;
    end else if (wrap) begin
      cnt_next = 8'h00;
      phase_next = phase_reg + 2'b01;
    end else begin
      cnt_next = cnt_reg + 8'h01;
      phase_next = phase_reg;
    end
  end

  // counter flops
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      cnt_reg <= 8'h00;
      phase_reg <= 2'b00;
    end else if (ce) begin
      cnt_reg <= cnt_next;
      phase_reg <= phase_next;
    end
  end

  // enables gathered per channel
  assign en_vec = {ctrl_reg.en1, ctrl_reg.en0};

  // per channel: software duty, active duty and waveform
  for (genvar ch = 0; ch < NCH; ch++) begin : g_ch
    wire        wr_this = (ch == 0) ? wr_duty0 : wr_duty1;

    // software-visible duty register
    always_ff @(posedge aclk) begin
      if (!aresetn) begin
        duty_reg[ch] <= `DFP_DUTY_RST;
      end else if (ce && wr_this) begin
        duty_reg[ch] <= wr.data;
      end
    end

    // active duty changes between periods while running, and every clock while stopped
    always_ff @(posedge aclk) begin
      if (!aresetn) begin
        act_reg[ch] <= `DFP_DUTY_RST;
      end else if (ce && take_duty) begin
        act_reg[ch] <= duty_reg[ch];
      end
    end

    // waveform generator
    dfp_channel u_ch (
      .aclk    (aclk),
      .aresetn (aresetn),
      .ce      (ce),
      .run     (ctrl_reg.run),
      .mode    (ctrl_reg.mode),
      .cnt     (cnt_reg),
      .phase   (phase_reg),
      .en      (en_vec[ch]),
      .duty    (act_reg[ch]),
      .pwm_out (pin[ch])
    );
  end

  // pins; high while stopped or disabled
  assign pwm_out_ch0 = pin[0] | unused_ok;
  assign pwm_out_ch1 = pin[1];
endmodule
`default_nettype wire

// File: verilog/dfp_cfg.svh
// offsets, field positions, reset values and counts for the dual fast pwm
`ifndef DFP_CFG_SVH
`define DFP_CFG_SVH
`define DFP_IDX_CTRL    6'h0c
`define DFP_IDX_DUTY0   6'h0d
`define DFP_IDX_DUTY1   6'h0e
`define DFP_IDX_STAT    6'h0f
`define DFP_POS_MODE    0
`define DFP_POS_RUN     3
`define DFP_POS_EN0     6
`define DFP_POS_EN1     7
`define DFP_CTRL_RST    8'h00
`define DFP_CTRL_MASK   8'hcb
`define DFP_DUTY_RST    8'h00
`define DFP_LAST_M8     8'hff
`define DFP_LAST_M7     8'h7f
`define DFP_LAST_M6     8'h3f
`define DFP_RESP_OKAY   2'b00
`define DFP_RESP_SLVERR 2'b10
`endif

// File: verilog/dfp_pkg.sv
// types shared by the dual fast pwm modules
`default_nettype none
package dfp_pkg;
  typedef enum logic [1:0] {
    DFP_M8   = 2'b00,
    DFP_M7   = 2'b01,
    DFP_M6   = 2'b10,
    DFP_MRSV = 2'b11
  } dfp_mode_e;
  typedef enum logic [1:0] {
    DFP_W_IDLE = 2'b01,
    DFP_W_RESP = 2'b10
  } dfp_wst_e;
  typedef struct packed {
    logic      en1;
    logic      en0;
    logic [1:0] rsv_hi;
    logic      run;
    logic      rsv_lo;
    dfp_mode_e mode;
  } dfp_ctrl_s;
  typedef struct packed {
    logic       wr;
    logic [5:0] idx;
    logic [7:0] data;
  } dfp_wr_s;
endpackage
`default_nettype wire

// File: verilog/dfp_axil_slave.sv
// axi4-lite slave front end for the pwm register file
`timescale 1ns/100ps
`default_nettype none
`include "dfp_cfg.svh"
module dfp_axil_slave #(
  parameter int AW = 8
) (
  // clock, reset, enable
  input  wire logic            aclk,
  input  wire logic            aresetn,
  input  wire logic            ce,
  // write channels
  input  wire logic            awvalid,
  output logic                 awready,
  input  wire logic [AW-1:0]   awaddr,
  input  wire logic            wvalid,
  output logic                 wready,
  input  wire logic [7:0]      wdata,
  input  wire logic            wstrb0,
  output logic                 bvalid,
  input  wire logic            bready,
  output logic [1:0]           bresp,
  // read channels
  input  wire logic            arvalid,
  output logic                 arready,
  input  wire logic [AW-1:0]   araddr,
  output logic                 rvalid,
  input  wire logic            rready,
  output logic [31:0]          rdata,
  output logic [1:0]           rresp,
  // register file side
  output dfp_pkg::dfp_wr_s     wr,
  input  wire logic            wr_hit,
  output logic [AW-3:0]        rd_idx,
  input  wire logic [31:0]     rd_data,
  input  wire logic            rd_hit
);
  import dfp_pkg::*;
  dfp_wst_e        wst_reg, wst_next;
  logic            aw_got_reg, w_got_reg;
  logic [AW-3:0]   widx_reg;
  logic [7:0]      wdat_reg;
  logic            wstb_reg;
  // either order of address and data, response after both
  wire             aw_hs   = awvalid & awready;
  wire             w_hs    = wvalid & wready;
  wire             aw_have = aw_got_reg | aw_hs;
  wire             w_have  = w_got_reg | w_hs;
  wire             do_wr   = aw_have & w_have & (wst_reg == DFP_W_IDLE);
  wire             ar_hs   = arvalid & arready;
  wire             rv_next = ar_hs | (rvalid & ~rready);
  wire             aw_next = aw_have & ~do_wr;
  wire             w_next  = w_have & ~do_wr;
  assign wst_next = do_wr ? DFP_W_RESP : ((bvalid & bready) ? DFP_W_IDLE : wst_reg);
  assign wr.wr    = do_wr & (w_got_reg ? wstb_reg : wstrb0);
  assign wr.idx   = aw_got_reg ? widx_reg[5:0] : awaddr[7:2];
  assign wr.data  = w_got_reg ? wdat_reg : wdata;
  assign rd_idx   = araddr[AW-1:2];
  // channel handshake flops
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      wst_reg <= DFP_W_IDLE;
      aw_got_reg <= 1'b0;
      w_got_reg <= 1'b0;
      widx_reg <= '0;
      wdat_reg <= 8'h00;
      wstb_reg <= 1'b0;
      awready <= 1'b0;
      wready <= 1'b0;
      bvalid <= 1'b0;
      bresp <= `DFP_RESP_OKAY;
      arready <= 1'b0;
      rvalid <= 1'b0;
      rdata <= 32'h0000_0000;
      rresp <= `DFP_RESP_OKAY;
    end else if (ce) begin
      wst_reg <= wst_next;
      aw_got_reg <= aw_next;
      w_got_reg <= w_next;
      if (aw_hs) widx_reg <= awaddr[AW-1:2];
      if (w_hs) wdat_reg <= wdata;
      if (w_hs) wstb_reg <= wstrb0;
      awready <= ~aw_next & (wst_next == DFP_W_IDLE);
      wready <= ~w_next & (wst_next == DFP_W_IDLE);
      bvalid <= (wst_next == DFP_W_RESP);
      if (do_wr) bresp <= wr_hit ? `DFP_RESP_OKAY : `DFP_RESP_SLVERR;
      arready <= ~rv_next;
      rvalid <= rv_next;
      if (ar_hs) rdata <= rd_hit ? rd_data : 32'h0000_0000;
      if (ar_hs) rresp <= rd_hit ? `DFP_RESP_OKAY : `DFP_RESP_SLVERR;
    end
  end
  if (AW < 8) begin : g_chk
    $error("dfp_axil_slave: AW must be at least 8");
  end
endmodule
`default_nettype wire

// File: verilog/dfp_channel.sv
// one pwm channel: width compare, dither and half-clock stretch
`timescale 1ns/100ps
`default_nettype none
module dfp_channel (
  // clock, reset, enable
  input  wire logic              aclk,
  input  wire logic              aresetn,
  input  wire logic              ce,
  // shared timing
  input  wire logic              run,
  input  wire dfp_pkg::dfp_mode_e mode,
  input  wire logic [7:0]        cnt,
  input  wire logic [1:0]        phase,
  // channel setup
  input  wire logic              en,
  input  wire logic [7:0]        duty,
  // pin, active low pulse
  output logic                   pwm_out
);
  import dfp_pkg::*;
  logic [7:0] width;
  logic       ext;
  logic       pos_reg;
  logic       neg_reg;
  logic       ext_reg;
  // whole-clock width and half-clock extension per mode
  always_comb begin
    case (mode)
      DFP_M7: begin
        width = {1'b0, duty[7:1]};
        ext = duty[0];
      end
      DFP_M6: begin
        width = {2'b00, duty[7:2]};
        ext = duty[1:0] > {phase[0], phase[1]};
      end
      default: begin
        width = duty;
        ext = 1'b0;
      end
    endcase
  end
  // low from period start for width clocks, high when stopped
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      pos_reg <= 1'b1;
      ext_reg <= 1'b0;
    end else if (ce) begin
      pos_reg <= ~(run & en & (cnt < width));
      ext_reg <= run & en & ext;
    end
  end
  // half-clock delayed copy stretches the low pulse by 1/2 clock
  always_ff @(negedge aclk) begin
    if (!aresetn) begin
      neg_reg <= 1'b1;
    end else if (ce) begin
      neg_reg <= pos_reg;
    end
  end
  assign pwm_out = pos_reg & (neg_reg | ~ext_reg);
endmodule
`default_nettype wire

// File: test/dfp_top_properties.sv
// port checker for the dual fast pwm, bound to its top
`timescale 1ns/100ps
`default_nettype none
`include "dfp_cfg.svh"
module dfp_top_properties #(
  parameter int AW = 8
) (
  // clock, reset, enable
  input wire logic          aclk,
  input wire logic          aresetn,
  input wire logic          ce,
  // axi4-lite write side
  input wire logic          s_axi_awvalid,
  input wire logic          s_axi_awready,
  input wire logic [AW-1:0] s_axi_awaddr,
  input wire logic          s_axi_wvalid,
  input wire logic          s_axi_wready,
  input wire logic          s_axi_bvalid,
  input wire logic          s_axi_bready,
  input wire logic [1:0]    s_axi_bresp,
  // axi4-lite read side
  input wire logic          s_axi_arvalid,
  input wire logic          s_axi_arready,
  input wire logic [AW-1:0] s_axi_araddr,
  input wire logic          s_axi_rvalid,
  input wire logic          s_axi_rready,
  input wire logic [31:0]   s_axi_rdata,
  input wire logic [1:0]    s_axi_rresp,
  // pwm pins
  input wire logic          pwm_out_ch0,
  input wire logic          pwm_out_ch1
);
  logic aw_hit;
  logic ar_hit;
  default clocking cb @(posedge aclk); endclocking
  default disable iff (!aresetn);
  // mapped window is byte 0x30 to 0x3f
  assign aw_hit = s_axi_awaddr[7:4] == 4'h3;
  assign ar_hit = s_axi_araddr[7:4] == 4'h3;
  // both write channels taken at one edge, and a read taken
  sequence s_wr_take;
    s_axi_awvalid && s_axi_awready && s_axi_wvalid && s_axi_wready && ce;
  endsequence
  sequence s_rd_take;
    s_axi_arvalid && s_axi_arready && ce;
  endsequence
  a_wr_okay:
  assert property (s_wr_take ##0 aw_hit |=> s_axi_bvalid && s_axi_bresp == `DFP_RESP_OKAY)
    else $error("mapped write not answered okay");
  a_wr_error:
  assert property (s_wr_take ##0 !aw_hit |=> s_axi_bvalid && s_axi_bresp == `DFP_RESP_SLVERR)
    else $error("unmapped write not refused");
  a_rd_okay:
  assert property (s_rd_take ##0 ar_hit |=> s_axi_rvalid && s_axi_rresp == `DFP_RESP_OKAY
                   && s_axi_rdata[31:10] == 22'h0)
    else $error("mapped read answer wrong");
  a_rd_error:
  assert property (s_rd_take ##0 !ar_hit |=> s_axi_rvalid && s_axi_rresp == `DFP_RESP_SLVERR
                   && s_axi_rdata == 32'h0)
    else $error("unmapped read answer wrong");
  a_b_hold:
  assert property (s_axi_bvalid && !s_axi_bready |=> s_axi_bvalid && $stable(s_axi_bresp))
    else $error("write response dropped early");
  a_r_hold:
  assert property (s_axi_rvalid && !s_axi_rready |=> s_axi_rvalid && $stable(s_axi_rdata))
    else $error("read data dropped early");
  a_b_block:
  assert property (s_axi_bvalid |-> !s_axi_awready && !s_axi_wready)
    else $error("write taken during response");
  a_r_block:
  assert property (s_axi_rvalid |-> !s_axi_arready)
    else $error("read taken during answer");
  a_rst_pins:
  assert property ($rose(aresetn) |-> pwm_out_ch0 && pwm_out_ch1 && !s_axi_bvalid && !s_axi_rvalid)
    else $error("pins or answers wrong after reset");
  a_pulse_span0:
  assert property ($fell(pwm_out_ch0) |-> ##[1:256] pwm_out_ch0)
    else $error("channel 0 low longer than a period");
  a_pulse_span1:
  assert property ($fell(pwm_out_ch1) |-> ##[1:256] pwm_out_ch1)
    else $error("channel 1 low longer than a period");
endmodule
bind dfp_top dfp_top_properties #(.AW(AW)) i_props (.*);
`default_nettype wire

// File: test/dfp_pin_model.sv
// port pin monitor: counts low pulses and sums their width
`timescale 1ns/100ps
`default_nettype none
module dfp_pin_model #(
  parameter realtime HALF = 20.0
) (
  // pwm pin and measure clear
  input  wire logic pin,
  input  wire logic clr,
  // pulses seen and summed low time in half clocks
  output int        pulses,
  output int        half_sum
);
  logic    port_pin;
  realtime t_fall = -1.0;
  // port latch held at one, so the pin follows the pwm output
  assign port_pin = pin & 1'h1;
  // start of a low pulse, forgotten while clearing
  always @(negedge port_pin or posedge clr)
    t_fall = clr ? -1.0 : $realtime;
  // end of a low pulse, first four after a clear
  always @(posedge port_pin or posedge clr) begin
    if (clr) begin
      pulses = 0;
      half_sum = 0;
    end else if (t_fall >= 0.0 && pulses < 4) begin
      pulses++;
      half_sum += int'(($realtime - t_fall) / HALF);
    end
  end
endmodule
`default_nettype wire

// File: test/dfp_top_bench.sv
// self-checking bench for the dual fast pwm
`timescale 1ns/100ps
`default_nettype none
`include "dfp_cfg.svh"
module dfp_top_bench;
  localparam logic [7:0] A_CT = {`DFP_IDX_CTRL, 2'h0};
  localparam logic [7:0] A_D0 = {`DFP_IDX_DUTY0, 2'h0};
  localparam logic [7:0] A_D1 = {`DFP_IDX_DUTY1, 2'h0};
  localparam logic [7:0] A_ST = {`DFP_IDX_STAT, 2'h0};
  localparam logic [1:0] OK = `DFP_RESP_OKAY;
  localparam logic [1:0] ER = `DFP_RESP_SLVERR;
  // clock, reset and bus drive
  logic        aclk = 1'h0;
  logic        aresetn = 1'h0;
  logic        ce = 1'h1;
  logic        clr = 1'h1;
  logic [2:0]  s_axi_awprot = 3'h0;
  logic [2:0]  s_axi_arprot = 3'h0;
  logic        s_axi_awvalid = 1'h0, s_axi_wvalid = 1'h0, s_axi_bready = 1'h0;
  logic        s_axi_arvalid = 1'h0, s_axi_rready = 1'h0;
  logic [7:0]  s_axi_awaddr = 8'h0, s_axi_araddr = 8'h0;
  logic [31:0] s_axi_wdata = 32'h0;
  logic [3:0]  s_axi_wstrb = 4'h0;
  // design answers and pin measures
  logic        s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid;
  logic [1:0]  s_axi_bresp, s_axi_rresp;
  logic [31:0] s_axi_rdata;
  logic        pwm_out_ch0, pwm_out_ch1;
  int          p0, h0, p1, h1;
  int          fail_count = 0;
  int          checks_done = 0;
  // clock and instances
  always #20 aclk = ~aclk;
  dfp_top i_dut (.*);
  dfp_pin_model i_pin0 (.pin(pwm_out_ch0), .clr(clr), .pulses(p0), .half_sum(h0));
  dfp_pin_model i_pin1 (.pin(pwm_out_ch1), .clr(clr), .pulses(p1), .half_sum(h1));
  // compare one result
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    checks_done++;
    if (got !== exp) begin
      fail_count++;
      $display("[FAIL] %0t got %h expected %h", $time, got, exp);
    end
  endtask
  // one write, address and data offered together
  task automatic wr(input logic [7:0] a, input logic [7:0] d, input logic [1:0] er);
    s_axi_awaddr <= a;
    s_axi_wdata <= {24'h0, d};
    s_axi_wstrb <= 4'hf;
    s_axi_awvalid <= 1'h1;
    s_axi_wvalid <= 1'h1;
    do begin
      @(posedge aclk);
      if (s_axi_awready) s_axi_awvalid <= 1'h0;
      if (s_axi_wready) s_axi_wvalid <= 1'h0;
    end while (s_axi_awvalid || s_axi_wvalid);
    @(posedge aclk);
    s_axi_bready <= 1'h1;
    do @(posedge aclk); while (!s_axi_bvalid);
    s_axi_bready <= 1'h0;
    chk(s_axi_bresp, er);
  endtask
  // one read, answer accepted a cycle late
  task automatic rd(input logic [7:0] a, input logic [31:0] ed, input logic [1:0] er);
    s_axi_araddr <= a;
    s_axi_arvalid <= 1'h1;
    do @(posedge aclk); while (!s_axi_arready);
    s_axi_arvalid <= 1'h0;
    @(posedge aclk);
    s_axi_rready <= 1'h1;
    do @(posedge aclk); while (!s_axi_rvalid);
    s_axi_rready <= 1'h0;
    chk(s_axi_rdata, ed);
    chk(s_axi_rresp, er);
  endtask
  // low time of four pulses in half clocks
  function automatic int hsum(input logic [1:0] m, input logic [7:0] d);
    if (m == 2'h2) return 8 * (d >> 2) + d[1:0];
    return (m == 2'h1) ? 4 * d : 8 * d;
  endfunction
  // one mode: control setup while stopped, run, duties written while running, measure, stop
  task automatic run_mode(input logic [1:0] m, input logic [7:0] d0, d1, input logic [1:0] en);
    logic [7:0] c;
    c = {en, 4'h0, m};
    clr <= 1'h1;
    wr(A_CT, c | 8'h34, OK);
    rd(A_CT, {24'h0, c}, OK);
    wr(A_CT, c | 8'h08, OK);
    wr(A_D0, d0, OK);
    wr(A_D1, d1, OK);
    rd(A_D0, {24'h0, d0}, OK);
    rd(A_D1, {24'h0, d1}, OK);
    clr <= 1'h0;
    repeat (6 * (256 >> m)) @(posedge aclk);
    chk(p0, 4);
    chk(h0, hsum(m, d0));
    chk(p1, en[1] ? 4 : 0);
    chk(h1, en[1] ? hsum(m, d1) : 0);
    wr(A_CT, c, OK);
    chk(pwm_out_ch0 & pwm_out_ch1, 1'h1);
    rd(A_CT, 32'h0, OK);
    $display("mode %0d test done", m);
  endtask
  // verdict and end of run
  task automatic finish_test;
    $display("checks %0d, mismatches %0d", checks_done, fail_count);
    if (fail_count == 0 && checks_done > 0) begin
      $display("Result: passed");
    end else begin
      $display("Result: failed");
    end
    $finish;
  endtask
  // reset, register map, then each mode
  initial begin
    repeat (6) @(posedge aclk);
    aresetn <= 1'h1;
    repeat (2) @(posedge aclk);
    rd(A_CT, 32'h0, OK);
    rd(A_D0, 32'h0, OK);
    rd(A_D1, 32'h0, OK);
    wr(A_ST, 8'h5a, OK);
    rd(A_ST, 32'h0, OK);
    wr(8'h44, 8'h5a, ER);
    rd(8'h40, 32'h0, ER);
    chk(pwm_out_ch0 & pwm_out_ch1, 1'h1);
    $display("register test done");
    run_mode(2'h0, 8'h10, 8'hf0, 2'h3);
    run_mode(2'h1, 8'he7, 8'h11, 2'h1);
    run_mode(2'h2, 8'h41, 8'he3, 2'h3);
    wr(A_CT, 8'h00, OK);
    finish_test;
  end
  // cut a hang short
  initial begin
    repeat (20000) @(posedge aclk);
    fail_count++;
    $display("[FAIL] %0t watchdog expired", $time);
    finish_test;
  end
endmodule
`default_nettype wire
